// ===== logic/spp_pkg.sv
`default_nettype none
package spp_pkg;
    // Clock period in picoseconds (125 MHz)
    localparam int unsigned CLK_PS = 8000;
    // Timer width shared by every winding counter except the 2-bit consecutive count
    localparam int unsigned TMR_W = 16;

    // Nominal times in tenths of a microsecond, except the _NS one
    localparam int unsigned DEAD_NS10 = 5;
    localparam int unsigned BLANK_SHORT_NS10 = 17;
    localparam int unsigned BLANK_LONG_NS10 = 32;
    localparam int unsigned OPEN_CONFIRM_NS = 2000;

    // Least times round up to whole cycles
    localparam int unsigned DEAD_CYC = (DEAD_NS10 * 100000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned BLANK_SHORT_CYC = (BLANK_SHORT_NS10 * 100000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned BLANK_LONG_CYC = (BLANK_LONG_NS10 * 100000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned OPEN_CONFIRM_CYC = (OPEN_CONFIRM_NS * 1000 + CLK_PS - 1) / CLK_PS;

    // Consecutive open detections needed before shutdown
    localparam logic [1:0] OPEN_CONSEC = 2'h3;
    // Reset values
    localparam logic [1:0] CONSEC_RST = 2'h0;
    localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;

    // Per-winding chopping phase
    typedef enum logic [2:0] {
        SPP_IDLE,
        SPP_DEAD_ON,
        SPP_ON,
        SPP_DEAD_OFF,
        SPP_OFF
    } spp_state_t;
endpackage : spp_pkg
`default_nettype wire

// ===== logic/spp_top.sv
// What this block does
// - OFF period ends on timer, not current
// - OFF duration picked from three ratio levels
// - Opposite transistor conducts during OFF period
// - About 0.5 us dead time between transistors
// - Sense above short threshold disables outputs
// - Short shutdown latched until supply cycled
// - Positive sense during OFF flags open
// - Open protection after three consecutive detections
// - Shut down only if breakdown exceeds delay
// - Over-temperature disables all outputs
// - ON until reference reached, then OFF
// - Comparator ignored during blanking after turn-on
`timescale 1ns/1ps
`default_nettype none
module spp_top #(
    parameter int unsigned N_WIND    = 2,
    parameter bit          LONG_BLANK = 1'b0,
    parameter int unsigned OFF0_NS   = 10000,
    parameter int unsigned OFF1_NS   = 7000,
    parameter int unsigned OFF2_NS   = 4000
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    // Sequencer side, per winding
    input  wire logic [N_WIND-1:0]   drive_en_i,
    input  wire logic [N_WIND-1:0]   phase_sel_i,
    input  wire logic [2*N_WIND-1:0] ratio_lvl_i,
    // Comparators, per winding
    input  wire logic [N_WIND-1:0]   trip_cmp_i,
    input  wire logic [N_WIND-1:0]   short_cmp_i,
    input  wire logic [N_WIND-1:0]   sense_pos_i,
    // Die temperature above thermal_trip_temperature
    input  wire logic                over_temp_i,
    // Gate controls, per winding
    output logic      [N_WIND-1:0]   drive_a_o,
    output logic      [N_WIND-1:0]   drive_b_o,
    // Fault indications
    output logic                     short_fault_o,
    output logic      [N_WIND-1:0]   open_fault_o,
    output logic                     over_temp_fault_o
);
    import spp_pkg::*;

    // Cycle counts for the three pwm_off_duration levels
    localparam logic [TMR_W-1:0] OFF0_CYC = TMR_W'((OFF0_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TMR_W-1:0] OFF1_CYC = TMR_W'((OFF1_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TMR_W-1:0] OFF2_CYC = TMR_W'((OFF2_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [TMR_W-1:0] DEAD_T   = TMR_W'(DEAD_CYC - 1);
    localparam logic [TMR_W-1:0] BLANK_T  =
        TMR_W'((LONG_BLANK ? BLANK_LONG_CYC : BLANK_SHORT_CYC) - 1);
    localparam logic [TMR_W-1:0] OPEN_T   = TMR_W'(OPEN_CONFIRM_CYC);

    logic short_r;
    logic ot_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Short latch: only a supply cycle (power-on reset) clears it
    // short latch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            short_r <= 1'b0;
        end else if (|short_cmp_i) begin
            short_r <= 1'b1;
        end
    end

    // Thermal latch, sticky like the short one
    // thermal latch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ot_r <= 1'b0;
        end else if (over_temp_i) begin
            ot_r <= 1'b1;
        end
    end

    assign short_fault_o     = short_r;
    assign over_temp_fault_o = ot_r;

    // Short latch never drops once set
    short_hold_a: assert property (short_r |=> short_r)
        else $error("short latch released");
    // Thermal trip kills both gates within two edges
    thermal_off_a: assert property (over_temp_i |=> ot_r ##1 (drive_a_o == '0 && drive_b_o == '0))
        else $error("gates on after thermal trip");

    genvar w;
    generate
        for (w = 0; w < N_WIND; w++) begin : g_wind
            spp_state_t       st_r;
            logic [TMR_W-1:0] tmr_r;
            logic [TMR_W-1:0] off_t;
            logic [TMR_W-1:0] acc_r;
            logic [1:0]       consec_r;
            logic             seen_r;
            logic             side_r;
            logic             open_r;
            logic             kill;
            logic             main_g;
            logic             sync_g;
            logic             off_end;
            logic [TMR_W-1:0] gap_r;
            logic [TMR_W-1:0] sync_len_r;

            // Short, thermal or own open latch, or a live short compare, forces the winding idle
            // output kill
            assign kill = short_r | ot_r | open_r | (|short_cmp_i);

            // Level 3 is unused by the sequencer; treat as shortest
            // off level select
            always_comb begin
                case (ratio_lvl_i[2*w +: 2])
                    2'h0:    off_t = OFF0_CYC - 16'h0001;
                    2'h1:    off_t = OFF1_CYC - 16'h0001;
                    default: off_t = OFF2_CYC - 16'h0001;
                endcase
            end

            assign off_end = (st_r == SPP_OFF) && (tmr_r == TMR_RST);

            // Chopping sequence; timer counts down in every phase but IDLE
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    st_r   <= SPP_IDLE;
                    tmr_r  <= TMR_RST;
                    side_r <= 1'b0;
                end else if (kill || !drive_en_i[w] ||
                             (st_r != SPP_IDLE && phase_sel_i[w] != side_r)) begin
                    st_r  <= SPP_IDLE;
                    tmr_r <= TMR_RST;
                end else begin
                    case (st_r)
                        SPP_IDLE: begin
                            side_r <= phase_sel_i[w];
                            st_r   <= SPP_DEAD_ON;
                            tmr_r  <= DEAD_T;
                        end
                        SPP_DEAD_ON: begin
                            if (tmr_r == TMR_RST) begin
                                st_r  <= SPP_ON;
                                tmr_r <= BLANK_T;
                            end else begin
                                tmr_r <= tmr_r - 16'h0001;
                            end
                        end
                        SPP_ON: begin
                            if (tmr_r != TMR_RST) begin
                                tmr_r <= tmr_r - 16'h0001;
                            end else if (trip_cmp_i[w]) begin
                                st_r  <= SPP_DEAD_OFF;
                                tmr_r <= DEAD_T;
                            end
                        end
                        SPP_DEAD_OFF: begin
                            if (tmr_r == TMR_RST) begin
                                st_r  <= SPP_OFF;
                                tmr_r <= off_t;
                            end else begin
                                tmr_r <= tmr_r - 16'h0001;
                            end
                        end
                        SPP_OFF: begin
                            if (tmr_r == TMR_RST) begin
                                st_r  <= SPP_DEAD_ON;
                                tmr_r <= DEAD_T;
                            end else begin
                                tmr_r <= tmr_r - 16'h0001;
                            end
                        end
                        default: begin
                            st_r  <= SPP_IDLE;
                            tmr_r <= TMR_RST;
                        end
                    endcase
                end
            end

            // Gate decode: excited side in ON, opposite in OFF
            // synchronous rectification
            assign main_g = (st_r == SPP_ON);
            assign sync_g = (st_r == SPP_OFF);
            assign drive_a_o[w] = side_r ? sync_g : main_g;
            assign drive_b_o[w] = side_r ? main_g : sync_g;

            // Open detection per OFF period
            // positive sense flag
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    seen_r <= 1'b0;
                end else if (st_r != SPP_OFF || off_end) begin
                    seen_r <= 1'b0;
                end else if (sense_pos_i[w]) begin
                    seen_r <= 1'b1;
                end
            end

            // Consecutive count and accumulated breakdown time
            // consecutive count
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    consec_r <= CONSEC_RST;
                    acc_r    <= TMR_RST;
                end else begin
                    if (st_r == SPP_OFF && sense_pos_i[w] && acc_r != '1) begin
                        acc_r <= acc_r + 16'h0001;
                    end
                    if (off_end) begin
                        if (seen_r || sense_pos_i[w]) begin
                            if (consec_r != OPEN_CONSEC) begin
                                consec_r <= consec_r + 2'h1;
                            end
                        end else begin
                            consec_r <= CONSEC_RST;
                            acc_r    <= TMR_RST;
                        end
                    end
                end
            end

            // Short bursts of surge reach the delay only by adding up over consecutive OFF periods
            // open latch
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    open_r <= 1'b0;
                end else if (consec_r == OPEN_CONSEC && acc_r > OPEN_T) begin
                    open_r <= 1'b1;
                end
            end
            assign open_fault_o[w] = open_r;

            // Gates-off run length; a new pulse must follow a full dead time
            // dead gap length
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    gap_r <= TMR_RST;
                end else if (drive_a_o[w] || drive_b_o[w]) begin
                    gap_r <= TMR_RST;
                end else if (gap_r != '1) begin
                    gap_r <= gap_r + 16'h0001;
                end
            end

            // Rectifier pulse length, kept apart from the state timer
            // off length
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    sync_len_r <= TMR_RST;
                end else if (sync_g) begin
                    sync_len_r <= sync_len_r + 16'h0001;
                end else begin
                    sync_len_r <= TMR_RST;
                end
            end

            // Entry into the rectifying phase
            sequence off_entry_s;
                st_r == SPP_DEAD_OFF && tmr_r == TMR_RST && !kill ##1 st_r == SPP_OFF;
            endsequence
            sequence trip_seen_s;
                st_r == SPP_ON && tmr_r == TMR_RST && trip_cmp_i[w] && !kill
                    && drive_en_i[w] && phase_sel_i[w] == side_r;
            endsequence

            no_overlap_a: assert property (!(drive_a_o[w] && drive_b_o[w]))
                else $error("both transistors on");
            dead_gap_a: assert property ($fell(main_g) |-> !sync_g [*8])
                else $error("rectifier on inside dead time");
            short_kill_a: assert property (short_r |-> !drive_a_o[w] && !drive_b_o[w])
                else $error("gate on while short latched");
            trip_off_a: assert property (trip_seen_s |=> st_r == SPP_DEAD_OFF)
                else $error("trip did not end ON period");
            blank_hold_a: assert property (st_r == SPP_ON && tmr_r != TMR_RST && !kill
                    && drive_en_i[w] && phase_sel_i[w] == side_r |=> st_r == SPP_ON)
                else $error("ON ended inside blanking");
            off_sync_a: assert property (off_entry_s |-> (side_r ? drive_a_o[w] && !drive_b_o[w]
                    : drive_b_o[w] && !drive_a_o[w]))
                else $error("rectifier off in OFF period");
            off_timer_a: assert property (st_r == SPP_OFF && tmr_r != TMR_RST && !kill
                    && drive_en_i[w] && phase_sel_i[w] == side_r |=> st_r == SPP_OFF)
                else $error("OFF period ended early");
            clean_clear_a: assert property (off_end && !seen_r && !sense_pos_i[w]
                    |=> consec_r == CONSEC_RST && acc_r == TMR_RST)
                else $error("open counter not cleared");
            open_three_a: assert property ($rose(open_r) |-> $past(consec_r) == OPEN_CONSEC
                    && $past(acc_r) > OPEN_T)
                else $error("open latched too early");
            // Whole dead time before any gate turns on, not just a few cycles
            dead_full_a: assert property ($rose(drive_a_o[w] || drive_b_o[w])
                    |-> gap_r >= TMR_W'(DEAD_CYC))
                else $error("gate on before full dead time");
            off_len_a: assert property ($fell(sync_g) && st_r == SPP_DEAD_ON
                    |-> (sync_len_r == OFF0_CYC || sync_len_r == OFF1_CYC
                    || sync_len_r == OFF2_CYC))
                else $error("OFF length not one of the levels");
            open_kill_a: assert property (open_r |=> !drive_a_o[w] && !drive_b_o[w])
                else $error("gate on after open latched");
        end
    endgenerate
endmodule : spp_top
`default_nettype wire

// ===== verification/spp_winding_model.sv
`timescale 1ns/1ps
`default_nettype none
// One winding with its switches and sense resistor
module spp_winding_model (
    // Clock
    input  wire logic        clk_i,
    // Gate controls from the block
    input  wire logic        gate_a_i,
    input  wire logic        gate_b_i,
    // Bench controls: ramp length and injected faults
    input  wire logic [15:0] on_len_i,
    input  wire logic        open_i,
    input  wire logic        short_i,
    // Comparator outputs
    output logic             trip_cmp_o,
    output logic             short_cmp_o,
    output logic             sense_pos_o
);
    logic [15:0] cond_r = 16'h0000;

    // Current ramps only while a gate conducts
    always_ff @(posedge clk_i) begin
        cond_r <= (gate_a_i | gate_b_i) ? cond_r + 16'h0001 : 16'h0000;
    end
    // Trip once the ramp reaches target_current
    assign trip_cmp_o  = (cond_r >= on_len_i);
    // A shorted coil shows only while current flows
    assign short_cmp_o = short_i & (gate_a_i | gate_b_i);
    // Broken coil: sense goes positive while gate b conducts
    assign sense_pos_o = open_i & gate_b_i;
endmodule : spp_winding_model
`default_nettype wire

// ===== verification/stepper_pwm_protection_bench.sv
`timescale 1ns/1ps
`default_nettype none
module stepper_pwm_protection_bench;
    import spp_pkg::*;
    typedef struct {logic [1:0] lvl; int off;} spp_row_t;
    // Ratio level beside OFF cycles for the OFF params set below
    spp_row_t    rows [4] = '{'{2'h0, 100}, '{2'h1, 70}, '{2'h2, 40}, '{2'h3, 40}};
    logic        clk_i       = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic [1:0]  drive_en_i  = 2'h0;
    logic [3:0]  ratio_lvl_i = 4'h0;
    logic        over_temp_i = 1'b0;
    logic [1:0]  phase_sel_i = 2'h0;
    logic        open_r      = 1'b0;
    logic        short_r     = 1'b0;
    logic [15:0] on_len_r    = 16'h00FA;
    logic [1:0]  trip_cmp, short_cmp, sense_pos, drive_a_o, drive_b_o, open_fault_o;
    logic        short_fault_o, over_temp_fault_o;
    int failures = 0, checks_done = 0, a_len = 0, b_len = 0, gap = 0;
    int a_last = 0, b_last = 0, gap_last = 0, b_pulses = 0;

    spp_top #(.N_WIND(2), .OFF0_NS(800), .OFF1_NS(560), .OFF2_NS(320)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .drive_en_i(drive_en_i), .phase_sel_i(phase_sel_i),
        .ratio_lvl_i(ratio_lvl_i), .trip_cmp_i(trip_cmp), .short_cmp_i(short_cmp),
        .sense_pos_i(sense_pos), .over_temp_i(over_temp_i), .drive_a_o(drive_a_o),
        .drive_b_o(drive_b_o), .short_fault_o(short_fault_o),
        .open_fault_o(open_fault_o), .over_temp_fault_o(over_temp_fault_o));
    // Far side of each winding
    for (genvar w = 0; w < 2; w++) begin : g_wind
        spp_winding_model model (.clk_i(clk_i), .gate_a_i(drive_a_o[w]),
            .gate_b_i(drive_b_o[w]), .on_len_i(on_len_r), .open_i(open_r),
            .short_i(short_r), .trip_cmp_o(trip_cmp[w]), .short_cmp_o(short_cmp[w]),
            .sense_pos_o(sense_pos[w]));
    end

    // Free-running clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic final_report;
        if (failures == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %0h expected %0h", $time, msg, got, exp);
        end
    endtask : check

    task automatic check_rng(input int got, input int lo, input int hi, input string msg);
        checks_done++;
        if (got < lo || got > hi) begin
            failures++;
            $display("mismatch at %0t: %s got %0d outside %0d..%0d", $time, msg, got, lo, hi);
        end
    endtask : check_rng

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cycles

    // Bounded wait for n more finished gate-b pulses on winding 0, sampled mid-cycle
    task automatic wait_off(input int n);
        int t;
        t = b_pulses + n;
        for (int k = 0; k < 5000 && b_pulses < t; k++) @(negedge clk_i);
        if (b_pulses < t) check(32'h0, 32'h1, "OFF period missing");
    endtask : wait_off

    task automatic run(input logic [1:0] lvl);
        @(posedge clk_i);
        ratio_lvl_i <= {lvl, lvl};
        drive_en_i  <= 2'h3;
    endtask : run

    task automatic stop_reset(input bit do_rst);
        @(posedge clk_i);
        drive_en_i <= 2'h0;
        phase_sel_i <= 2'h0;
        rst_n_i    <= !do_rst;
        cycles(20);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
    endtask : stop_reset

    // Pulse and dead-gap lengths on winding 0, pre-edge values
    always @(posedge clk_i) begin
        if (drive_a_o[0]) a_len++;
        else if (a_len > 0) begin a_last = a_len; a_len = 0; end
        if (drive_b_o[0]) b_len++;
        else if (b_len > 0) begin b_last = b_len; b_len = 0; b_pulses++; end
        if (drive_a_o[0] | drive_b_o[0]) begin
            if (gap > 0) gap_last = gap;
            gap = 0;
        end else gap++;
        if (drive_a_o[0] & drive_b_o[0]) check(32'h1, 32'h0, "gates overlap");
    end

    // Watchdog, well beyond the expected ~8.3k cycles
    initial begin
        #(40000 * 8);
        failures++;
        final_report();
    end

    initial begin
        cycles(20);
        @(negedge clk_i);
        check(32'({drive_a_o, drive_b_o, open_fault_o, short_fault_o, over_temp_fault_o}),
              32'h0, "outputs in reset");
        stop_reset(1'b0);
        foreach (rows[i]) begin
            run(rows[i].lvl);
            wait_off(1);
            check(32'(b_last), 32'(rows[i].off), "OFF length");
            check(32'(gap_last), 32'(DEAD_CYC), "dead gap");
            check_rng(a_last, 250, 253, "ON length");
            stop_reset(1'b0);
        end
        // Side b excited: transistor a becomes the rectifier
        run(2'h0);
        phase_sel_i <= 2'h3;
        wait_off(2);
        check(32'(a_last), 32'd100, "side b rectifier");
        check_rng(b_last, 250, 253, "side b ON length");
        stop_reset(1'b0);
        // Trip held high from turn-on is ignored until blanking ends
        @(posedge clk_i) on_len_r <= 16'h0001;
        run(2'h0);
        wait_off(1);
        check_rng(a_last, BLANK_SHORT_CYC, BLANK_SHORT_CYC + 3, "blanking");
        check(32'(b_last), 32'd100, "rectifier on for OFF");
        @(posedge clk_i) on_len_r <= 16'h00FA;
        stop_reset(1'b0);
        // Two open, one clean, two open: no fault; third in a row trips
        @(posedge clk_i) open_r <= 1'b1;
        run(2'h0);
        wait_off(2);
        @(posedge clk_i) open_r <= 1'b0;
        wait_off(1);
        @(posedge clk_i) open_r <= 1'b1;
        wait_off(2);
        check(32'(open_fault_o), 32'h0, "open after clean OFF");
        wait_off(1);
        cycles(3);
        check(32'(open_fault_o), 32'h3, "open fault");
        check(32'({drive_a_o, drive_b_o}), 32'h0, "open disables");
        stop_reset(1'b1);
        check(32'(open_fault_o), 32'h0, "open cleared");
        // Three short breakdowns stay below the confirm delay
        run(2'h2);
        wait_off(3);
        check(32'(open_fault_o), 32'h0, "short breakdowns");
        @(posedge clk_i) open_r <= 1'b0;
        stop_reset(1'b1);
        // Short while driving: latched until reset
        run(2'h0);
        cycles(120);
        short_r <= 1'b1;
        cycles(3);
        check(32'({drive_a_o, drive_b_o, short_fault_o}), 32'h1, "short");
        short_r <= 1'b0;
        cycles(400);
        check(32'({drive_a_o, drive_b_o, short_fault_o}), 32'h1, "short held");
        stop_reset(1'b1);
        check(32'(short_fault_o), 32'h0, "short cleared");
        // One-cycle thermal indication latches and stops all gates
        run(2'h0);
        cycles(120);
        over_temp_i <= 1'b1;
        cycles(1);
        over_temp_i <= 1'b0;
        cycles(300);
        check(32'({drive_a_o, drive_b_o, over_temp_fault_o}), 32'h1, "thermal");
        stop_reset(1'b1);
        check(32'(over_temp_fault_o), 32'h0, "thermal cleared");
        final_report();
    end
endmodule : stepper_pwm_protection_bench
`default_nettype wire
